/* core/spi_frame_sync_control.sv */
// framed-mode sync pulse control for a serial peripheral port
//
// Strobed register access and the register addresses were chosen for this implementation.
module spi_frame_sync_control (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // register port
   input wire logic [spi_frame_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [spi_frame_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [spi_frame_pkg::DATA_W-1:0] reg_rdata,
   // link pins: bit clock and slave select / frame sync
   input wire logic bit_clock_pin,
   input wire logic slave_select_pin_in,
   output logic slave_select_pin_out,
   output logic slave_select_pin_oe,
   // shift engine side
   input wire logic frame_request,
   output logic frame_begin,
   output logic frame_active,
   output logic framed_mode
);
   import spi_frame_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic framed_mode_enable; // control bit 15
   logic sync_pulse_direction; // control bit 14, 1 = slave
   logic sync_pulse_polarity; // control bit 13, 1 = active high
   logic sync_pulse_edge_select; // control bit 1, 1 = coincide
   logic next_enable;
   logic next_direction;
   logic next_polarity;
   logic next_edge;
   logic [DATA_W-1:0] next_rdata;
   logic [DATA_W-1:0] ctrl_word; // read view of the control register
   logic [DATA_W-1:0] status_word; // read view of the sequencer
   logic [1:0] pin_sync; // synchronised bit clock and slave select
   logic sck_sync;
   logic ss_sync;
   logic sck_prev; // last sampled bit clock, for edge finding
   logic next_sck_prev;
   logic sck_rise; // one core cycle per bit clock rising edge
   logic sync_seen; // incoming sync at its active level
   logic begin_event; // a frame's sync pulse starts now
   frame_state_type state;
   frame_state_type next_state;
   logic [3:0] bit_cnt; // bit index inside the running frame
   logic [3:0] next_bit_cnt;
   logic sync_on; // master is holding the sync pulse active
   logic next_sync_on;
   logic next_frame_begin;
   logic next_frame_active;
   logic next_ss_out;
   logic next_ss_oe;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation: both pins are asynchronous to core_clk
   sync_2ff #(
      .WIDTH(2)
   ) u_pin_sync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .async_in({bit_clock_pin, slave_select_pin_in}),
      .sync_out(pin_sync)
   );

   assign sck_sync = pin_sync[1];
   assign ss_sync = pin_sync[0];
   // bit clock must stay above two core cycles per phase to be seen
   assign sck_rise = sck_sync & ~sck_prev;
   // incoming pulse compared against the programmed active level
   assign sync_seen = (ss_sync == sync_pulse_polarity);
   // master starts from an armed request, slave from a seen pulse
   assign begin_event = sck_rise & (sync_pulse_direction ?
      (state == ST_IDLE) & sync_seen : (state == ST_ARMED));

   ////////////////////////////////////////////////////////////////////////////
   // register file: next values
   always_comb begin
      next_enable = framed_mode_enable;
      next_direction = sync_pulse_direction;
      next_polarity = sync_pulse_polarity;
      next_edge = sync_pulse_edge_select;
      // only the four implemented bits are kept; the rest drop on write
      ctrl_word = CTRL_RESET;
      ctrl_word[BIT_ENABLE] = framed_mode_enable;
      ctrl_word[BIT_DIR] = sync_pulse_direction;
      ctrl_word[BIT_POL] = sync_pulse_polarity;
      ctrl_word[BIT_EDGE] = sync_pulse_edge_select;
      status_word = {STATUS_PAD, frame_active, sync_on, state, bit_cnt};
      if (reg_write && reg_addr == REG_CTRL) begin
         next_enable = reg_wdata[BIT_ENABLE];
         next_direction = reg_wdata[BIT_DIR];
         next_polarity = reg_wdata[BIT_POL];
         next_edge = reg_wdata[BIT_EDGE];
      end
      // read data stands only in the cycle after the strobe
      next_rdata = '0;
      if (reg_read) begin
         unique case (reg_addr)
            REG_CTRL: begin
               next_rdata = ctrl_word;
            end
            REG_STATUS: begin
               next_rdata = status_word;
            end
            default: begin
               next_rdata = '0; // unmapped reads answer zero
            end
         endcase
      end
   end

   // register file: storage, all control bits clear at reset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         framed_mode_enable <= CTRL_RESET[BIT_ENABLE];
         sync_pulse_direction <= CTRL_RESET[BIT_DIR];
         sync_pulse_polarity <= CTRL_RESET[BIT_POL];
         sync_pulse_edge_select <= CTRL_RESET[BIT_EDGE];
         reg_rdata <= '0;
      end else begin
         framed_mode_enable <= next_enable;
         sync_pulse_direction <= next_direction;
         sync_pulse_polarity <= next_polarity;
         sync_pulse_edge_select <= next_edge;
         reg_rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // framing sequencer: next values
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_sync_on = sync_on;
      next_frame_begin = 1'b0;
      next_sck_prev = sck_sync;
      if (!framed_mode_enable) begin
         // leaving framed mode abandons any frame in flight
         next_state = ST_IDLE;
         next_bit_cnt = CNT_ZERO;
         next_sync_on = 1'b0;
      end else begin
         // a master pulse lasts exactly one bit clock period
         if (sck_rise) begin
            next_sync_on = 1'b0;
         end
         unique case (state)
            ST_IDLE: begin
               // requests count only when this end makes the pulse
               if (!sync_pulse_direction && frame_request) begin
                  next_state = ST_ARMED;
               end
            end
            ST_ARMED: begin
               // turned into a slave while armed: drop the request
               if (sync_pulse_direction) begin
                  next_state = ST_IDLE;
               end
            end
            ST_SYNC: begin
               // early pulse: the first bit clock follows one period later
               if (sck_rise) begin
                  next_state = ST_RUN;
                  next_frame_begin = 1'b1;
                  next_bit_cnt = CNT_ZERO;
               end
            end
            ST_RUN: begin
               if (sck_rise) begin
                  if (bit_cnt == CNT_LAST) begin
                     next_state = ST_IDLE;
                  end else begin
                     next_bit_cnt = bit_cnt + CNT_STEP;
                  end
               end
            end
         endcase
         if (begin_event) begin
            next_sync_on = ~sync_pulse_direction;
            if (sync_pulse_edge_select) begin
               next_state = ST_RUN;
               next_frame_begin = 1'b1;
               next_bit_cnt = CNT_ZERO;
            end else begin
               next_state = ST_SYNC;
            end
         end
      end
      next_frame_active = (next_state == ST_RUN);
      // pin is driven only as a framed master
      next_ss_oe = framed_mode_enable & ~sync_pulse_direction;
      if (next_ss_oe) begin
         next_ss_out = next_sync_on ? sync_pulse_polarity : ~sync_pulse_polarity;
      end else begin
         next_ss_out = 1'b0;
      end
   end

   // framing sequencer: storage
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         bit_cnt <= CNT_ZERO;
         sync_on <= 1'b0;
         sck_prev <= 1'b0;
         frame_begin <= 1'b0;
         frame_active <= 1'b0;
         slave_select_pin_out <= 1'b0;
         slave_select_pin_oe <= 1'b0;
         framed_mode <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         sync_on <= next_sync_on;
         sck_prev <= next_sck_prev;
         frame_begin <= next_frame_begin;
         frame_active <= next_frame_active;
         slave_select_pin_out <= next_ss_out;
         slave_select_pin_oe <= next_ss_oe;
         framed_mode <= framed_mode_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks on the behaviour above

   // framed mode off: pin released and sequencer idle next cycle
   property p_disable_releases;
      @(posedge core_clk) disable iff (!reset_n)
      !framed_mode_enable |=> !slave_select_pin_oe && state == ST_IDLE && !frame_active;
   endproperty
   a_disable_releases: assert property (p_disable_releases)
      else $error("framed mode off but pin or frame still active");

   // master drives the pin, slave leaves it alone
   property p_direction_drive;
      @(posedge core_clk) disable iff (!reset_n)
      framed_mode_enable |=> slave_select_pin_oe == !$past(sync_pulse_direction);
   endproperty
   a_direction_drive: assert property (p_direction_drive)
      else $error("pin drive does not follow sync direction");

   // slave never arms from a request
   property p_slave_no_arm;
      @(posedge core_clk) disable iff (!reset_n)
      (sync_pulse_direction && framed_mode_enable && state == ST_IDLE)
         |=> state != ST_ARMED;
   endproperty
   a_slave_no_arm: assert property (p_slave_no_arm)
      else $error("slave armed a frame");

   // idle master holds the pin at the inactive level
   property p_idle_level;
      @(posedge core_clk) disable iff (!reset_n)
      (framed_mode_enable && !sync_pulse_direction && state == ST_IDLE && !sync_on)
         |=> slave_select_pin_out == !$past(sync_pulse_polarity);
   endproperty
   a_idle_level: assert property (p_idle_level)
      else $error("idle sync pin not at inactive level");

   // master pulse shows the active level while it lasts
   property p_pulse_level;
      @(posedge core_clk) disable iff (!reset_n)
      (sync_on && slave_select_pin_oe && $stable(sync_pulse_polarity))
         |-> slave_select_pin_out == sync_pulse_polarity;
   endproperty
   a_pulse_level: assert property (p_pulse_level)
      else $error("sync pulse not at active level");

   // coincident mode: frame begins right with the pulse
   property p_coincide;
      @(posedge core_clk) disable iff (!reset_n)
      (begin_event && framed_mode_enable && sync_pulse_edge_select)
         |=> frame_begin && frame_active ##1 !frame_begin;
   endproperty
   a_coincide: assert property (p_coincide)
      else $error("coincident frame did not begin with pulse");

   // early mode: frame waits for the next bit clock edge
   property p_early;
      @(posedge core_clk) disable iff (!reset_n)
      (begin_event && framed_mode_enable && !sync_pulse_edge_select)
         |=> !frame_begin && state == ST_SYNC;
   endproperty
   a_early: assert property (p_early)
      else $error("early pulse mode began frame too soon");

   // unused bits read zero
   property p_reserved_zero;
      @(posedge core_clk) disable iff (!reset_n)
      (reg_read && reg_addr == REG_CTRL) |=> (reg_rdata & ~CTRL_IMPL_MASK) == '0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("unused control bits read nonzero");

   // a written control word reads back masked
   property p_write_readback;
      @(posedge core_clk) disable iff (!reset_n)
      (reg_write && reg_addr == REG_CTRL)
         ##1 (reg_read && reg_addr == REG_CTRL && !reg_write)
         |=> reg_rdata == ($past(reg_wdata, 2) & CTRL_IMPL_MASK);
   endproperty
   a_write_readback: assert property (p_write_readback)
      else $error("control readback mismatch");
endmodule

/* core/spi_frame_pkg.sv */
// package of framing constants plus the two-flop input synchroniser
package spi_frame_pkg;
   // register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   // register indices on the plain register port
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   // field positions in the framing control register
   localparam int BIT_ENABLE = 15;
   localparam int BIT_DIR = 14;
   localparam int BIT_POL = 13;
   localparam int BIT_EDGE = 1;
   // reset value and mask of implemented control bits
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_IMPL_MASK = 16'hE002;
   // padding above the status fields
   localparam logic [5:0] STATUS_PAD = 6'h00;
   // frame geometry: bits per frame and index of the last bit
   localparam int FRAME_BITS = 16;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_STEP = 4'h1;
   localparam logic [3:0] CNT_LAST = 4'(FRAME_BITS - 1);
   // framing sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ARMED = 4'b0010,
      ST_SYNC  = 4'b0100,
      ST_RUN   = 4'b1000
   } frame_state_type;
endpackage

////////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for pins that come from outside core_clk
module sync_2ff #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // asynchronous inputs and their synchronised copies
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta; // first stage, read only by the second stage

   // plain flop chain; nothing may tap the first stage
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

/* test/frame_peer.sv */
// serial peer model: bit clock source and frame sync driver for slave-mode frames
module frame_peer (
   // link pins driven by the peer
   output logic bit_clk,
   output logic sync_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // half of the 160 ns bit period
   localparam time HALF = 80ns;
   ////////////////////////////////////////////////////////////////////////////////
   // the clock stands low between frames, sync rests at a neutral level
   initial begin
      bit_clk = 1'b0;
      sync_out = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one frame of bit clocks; sync is set half a period before each rise so the
   // port's two-flop sampler sees it settled at the rising edge
   task automatic run(input int nbits, input logic pulse, input logic level);
      for (int i = 0; i < nbits; i++) begin
         // active level only during the first bit clock, inactive elsewhere
         // non-blocking: in master frames these land on core clock edges and must not race the sampler
         sync_out <= (pulse && i == 0) ? level : ~level;
         #HALF;
         bit_clk <= 1'b1;
         #HALF;
         bit_clk <= 1'b0;
      end
   endtask
endmodule

/* test/testbench.sv */
// self-checking bench for the framed-mode sync control block
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import spi_frame_pkg::*;
   // clock, reset and register port
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic frame_request = 1'b0;
   logic [15:0] reg_rdata;
   // pins and engine side
   logic ss_out, ss_oe, frame_begin, frame_active, framed_mode;
   logic bit_clk, peer_sync, ss_line;
   logic pol = 1'b0;
   logic out_at_begin, act_at_begin;
   int error_cnt = 0;
   int cmp_count = 0;
   int begin_cnt = 0;
   int act_cnt = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // 125 MHz clock
   always #4 core_clk = ~core_clk;
   // the port drives the wire while ss_oe is set (framed master), otherwise the peer does
   assign ss_line = ss_oe ? ss_out : peer_sync;
   spi_frame_sync_control dut (
      .core_clk(core_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata),
      .bit_clock_pin(bit_clk), .slave_select_pin_in(ss_line),
      .slave_select_pin_out(ss_out), .slave_select_pin_oe(ss_oe),
      .frame_request(frame_request), .frame_begin(frame_begin),
      .frame_active(frame_active), .framed_mode(framed_mode)
   );
   frame_peer peer (.bit_clk(bit_clk), .sync_out(peer_sync));
   ////////////////////////////////////////////////////////////////////////////////
   // monitor: frame starts and length of the driven active pulse
   // sampled on the falling edge, where the registered outputs have settled
   always @(negedge core_clk) begin
      if (frame_begin === 1'b1) begin
         begin_cnt++;
         out_at_begin = ss_out;
         act_at_begin = frame_active;
      end
      if (ss_oe === 1'b1 && ss_out === pol) act_cnt++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // register access tasks
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe, then returns to zero
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1 `CHK(reg_rdata, e)
      @(posedge core_clk);
      #1 `CHK(reg_rdata, 16'h0000)
   endtask
   // write then read on the very next cycle, as the bus allows
   task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1 `CHK(reg_rdata, e)
   endtask
   task automatic req();
      @(posedge core_clk);
      frame_request <= 1'b1;
      @(posedge core_clk);
      frame_request <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // master frame with given polarity and edge select
   task automatic frame_master(input logic p, input logic e);
      pol = p;
      wr(REG_CTRL, {1'b1, 1'b0, p, 11'h000, e, 1'b0});
      repeat (2) @(posedge core_clk);
      #1 `CHK(framed_mode, 1'b1)
      `CHK(ss_oe, 1'b1)
      `CHK(ss_out, ~p)
      begin_cnt = 0;
      act_cnt = 0;
      req();
      peer.run(18, 1'b0, p);
      repeat (6) @(posedge core_clk);
      #1 `CHK(begin_cnt, 1)
      `CHK(act_cnt, 20)
      `CHK(out_at_begin, e ? p : ~p)
      `CHK(act_at_begin, 1'b1)
      `CHK(frame_active, 1'b0)
   endtask
   // slave frame: peer sends a pulse or none, local requests must be ignored
   task automatic frame_slave(input logic p, input logic pulse, input logic e);
      pol = p;
      wr(REG_CTRL, {1'b1, 1'b1, p, 11'h000, e, 1'b0});
      repeat (2) @(posedge core_clk);
      #1 `CHK(ss_oe, 1'b0)
      begin_cnt = 0;
      req();
      repeat (30) @(posedge core_clk);
      #1 `CHK(begin_cnt, 0)
      peer.run(18, pulse, p);
      repeat (6) @(posedge core_clk);
      #1 `CHK(begin_cnt, pulse ? 1 : 0)
      `CHK(frame_active, 1'b0)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 `CHK(ss_oe, 1'b0)
      `CHK(framed_mode, 1'b0)
      rd(REG_CTRL, CTRL_RESET);
      rd(REG_STATUS, 16'h0010);
      wr_rd(REG_CTRL, 16'h5FFF, 16'h4002);
      wr(REG_CTRL, 16'hFFFF);
      rd(REG_CTRL, 16'hE002);
      wr(4'h7, 16'h0000);
      rd(REG_CTRL, 16'hE002);
      rd(4'hF, 16'h0000);
      // every polarity and edge combination as master
      for (int i = 0; i < 4; i++) begin
         frame_master(i[1], i[0]);
      end
      frame_slave(1'b0, 1'b1, 1'b1);
      frame_slave(1'b0, 1'b1, 1'b0);
      frame_slave(1'b1, 1'b1, 1'b1);
      frame_slave(1'b1, 1'b0, 1'b1);
      // disabling in mid-frame aborts and releases the pin
      pol = 1'b1;
      wr(REG_CTRL, 16'hA002);
      req();
      fork
         peer.run(18, 1'b0, 1'b1);
         begin
            repeat (100) @(posedge core_clk);
            #1 `CHK(frame_active, 1'b1)
            wr(REG_CTRL, 16'h0000);
            repeat (2) @(posedge core_clk);
            #1 `CHK(frame_active, 1'b0)
            `CHK(ss_oe, 1'b0)
            `CHK(framed_mode, 1'b0)
         end
      join
      test_done();
   end
endmodule
